// ==== src/mmb_data_decode.sv ====
module mmb_data_decode (
  input  wire logic [1:0] bank_in,      // Bank select bits high:low
  input  wire logic [6:0] offset_in,    // In-bank offset
  output logic      [8:0] addr_out,     // Full data address
  output logic            sel_sfr_out,  // Special function area
  output logic            sel_gpr_out,  // Static RAM area
  output logic            mirrored_out  // Common register reached from any bank
);
  always_comb begin
    addr_out     = {bank_in, offset_in & mmb_pkg::OFS_MAX};
    sel_gpr_out  = (offset_in >= mmb_pkg::GPR_FIRST);
    sel_sfr_out  = !sel_gpr_out;
    mirrored_out = (offset_in == mmb_pkg::INDIRECT_OFS) || (offset_in == mmb_pkg::PCL_OFS)
                || (offset_in == mmb_pkg::STATUS_OFS) || (offset_in == mmb_pkg::PTR_OFS)
                || (offset_in == mmb_pkg::PCLATH_OFS)
                || (offset_in == mmb_pkg::INTCON_OFS);
  end
endmodule

// ==== src/mmb_memory_map.sv ====
// Overview of operation
// - Program and data paths are separate and both complete in one cycle.
// - Program counter is 13 bits, addressing 8K words of 14 bits.
// - Program storage exists only at 0000h-03FFh or 0000h-07FFh.
// - Upper counter bits are ignored, so higher fetches alias lower words.
// - Counter loads 0000h on reset and 0004h on an interrupt.
// - Status bits 6 and 5 select bank 0 to 3 for direct access; indirect access uses status bit 7 and pointer bit 7.
// - Each bank holds 128 byte offsets, 00h to 7Fh.
// - Special registers sit at low offsets, static RAM above them.
// - Common registers, status among them, decode to one copy in every bank.
// - Data EEPROM is reached only through its own address pointer.
// - Data space is reached directly or through the indirect pointer.
module mmb_memory_map #(
  parameter bit LARGE = 1'b0  // Selects 2K program and 256-byte EEPROM variant
) (
  input  wire logic                clk_in,           // Core clock, 125 MHz
  input  wire logic                arst_n_in,        // Asynchronous reset, active low
  input  wire logic                pc_load_in,       // Load counter (jump)
  input  wire logic [12:0]         pc_target_in,     // Jump target
  input  wire logic                irq_take_in,      // Interrupt taken
  input  wire logic                prog_wr_in,       // Program word write strobe
  input  wire logic [12:0]         prog_waddr_in,    // Program write address
  input  wire logic [13:0]         prog_wdata_in,    // Program write data
  input  wire mmb_pkg::mmb_dreq_s  dreq_in,          // Data access request
  input  wire logic                ee_ptr_wr_in,     // Load EEPROM address pointer
  input  wire logic [7:0]          ee_ptr_in,        // New EEPROM pointer value
  output logic      [12:0]         pc_out,           // Program counter
  output logic      [13:0]         insn_out,         // Fetched instruction word
  output mmb_pkg::mmb_dmap_s       dmap_out,         // Decoded data address
  output logic      [7:0]          rdata_out,        // Data read result
  output logic      [7:0]          status_out,       // Status register
  output logic      [7:0]          indirect_pointer_out, // Indirect pointer
  output logic      [7:0]          ee_addr_out       // EEPROM address pointer
);
  localparam int unsigned PAW = LARGE ? mmb_pkg::PROG_AW_LRG : mmb_pkg::PROG_AW_SML;
  localparam int unsigned EAW = LARGE ? mmb_pkg::EE_AW_LRG : mmb_pkg::EE_AW_SML;
  localparam int unsigned GPR_N = 2 ** mmb_pkg::DADDR_W;

  logic [1:0]  rst_sync_ff;
  logic        rst_n;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // Program side
  logic [13:0] prog_mem [2**PAW];
  logic [12:0] pc_ff;
  logic [12:0] nxt_pc;
  logic [13:0] insn_ff;
  logic [13:0] nxt_insn;

  always_comb begin
    if (irq_take_in) begin
      nxt_pc = mmb_pkg::IRQ_VECTOR;
    end else if (pc_load_in) begin
      nxt_pc = pc_target_in;
    end else begin
      nxt_pc = pc_ff + 13'h0001;
    end
    nxt_insn = prog_mem[pc_ff[PAW-1:0]];
  end

  always_ff @(posedge clk_in) begin
    if (prog_wr_in) begin
      prog_mem[prog_waddr_in[PAW-1:0]] <= prog_wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pc_ff   <= mmb_pkg::RESET_VECTOR;
      insn_ff <= 14'h0000;
    end else begin
      pc_ff   <= nxt_pc;
      insn_ff <= nxt_insn;
    end
  end

  // Data side
  logic [7:0]  status_ff;
  logic [7:0]  nxt_status;
  logic [7:0]  ptr_ff;
  logic [7:0]  nxt_ptr;
  logic [7:0]  pclath_ff;
  logic [7:0]  nxt_pclath;
  logic [7:0]  intcon_ff;
  logic [7:0]  nxt_intcon;
  logic [7:0]  ee_ff;
  logic [7:0]  nxt_ee;
  logic [7:0]  rdata_ff;
  logic [7:0]  nxt_rdata;
  mmb_pkg::mmb_dmap_s dmap_ff;
  mmb_pkg::mmb_dmap_s nxt_dmap;
  logic [7:0]  gpr_mem [GPR_N];
  logic [1:0]  bank;
  logic [6:0]  offset;
  logic [8:0]  daddr;
  logic        is_sfr;
  logic        is_gpr;
  logic        is_mirror;
  logic        wr_en;

  mmb_data_decode u_decode (
    .bank_in      (bank),
    .offset_in    (offset),
    .addr_out     (daddr),
    .sel_sfr_out  (is_sfr),
    .sel_gpr_out  (is_gpr),
    .mirrored_out (is_mirror)
  );

  // Address selection has its own process, so the decoder results read
  // further down never feed back into the process that drives them
  always_comb begin
    if (dreq_in.indirect) begin
      bank   = {status_ff[7], ptr_ff[7]};
      offset = ptr_ff[6:0];
    end else begin
      bank   = {status_ff[mmb_pkg::STAT_BSH_BIT], status_ff[mmb_pkg::STAT_BSL_BIT]};
      offset = dreq_in.offset;
    end
  end

  // EEPROM pointer stays outside the data map; it is only loaded and shown
  always_comb begin
    nxt_ee = ee_ff;
    if (ee_ptr_wr_in) begin
      nxt_ee = 8'(ee_ptr_in[EAW-1:0]);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ee_ff <= 8'h00;
    end else begin
      ee_ff <= nxt_ee;
    end
  end

  always_comb begin
    wr_en      = dreq_in.valid && dreq_in.write;
    nxt_status = status_ff;
    nxt_ptr    = ptr_ff;
    nxt_pclath = pclath_ff;
    nxt_intcon = intcon_ff;
    nxt_rdata  = rdata_ff;
    nxt_dmap = '{addr: daddr, bank: bank, offset: offset,
                 sel_sfr: is_sfr, sel_gpr: is_gpr, mirrored: is_mirror};
    if (dreq_in.valid && is_sfr && is_mirror) begin
      if (offset == mmb_pkg::STATUS_OFS) begin
        nxt_rdata = status_ff;
        if (wr_en) begin
          nxt_status = dreq_in.wdata;
        end
      end else if (offset == mmb_pkg::PTR_OFS) begin
        nxt_rdata = ptr_ff;
        if (wr_en) begin
          nxt_ptr = dreq_in.wdata;
        end
      end else if (offset == mmb_pkg::PCLATH_OFS) begin
        nxt_rdata = pclath_ff;
        if (wr_en) begin
          nxt_pclath = dreq_in.wdata;
        end
      end else if (offset == mmb_pkg::INTCON_OFS) begin
        nxt_rdata = intcon_ff;
        if (wr_en) begin
          nxt_intcon = dreq_in.wdata;
        end
      end else if (offset == mmb_pkg::PCL_OFS) begin
        nxt_rdata = pc_ff[7:0];
      end else begin
        nxt_rdata = 8'h00;
      end
    end else if (dreq_in.valid && is_gpr) begin
      nxt_rdata = gpr_mem[daddr];
    end else if (dreq_in.valid) begin
      nxt_rdata = 8'h00;
    end
  end

  always_ff @(posedge clk_in) begin
    if (wr_en && is_gpr) begin
      gpr_mem[daddr] <= dreq_in.wdata;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      status_ff <= mmb_pkg::STATUS_RST;
      ptr_ff    <= 8'h00;
      pclath_ff <= 8'h00;
      intcon_ff <= 8'h00;
      rdata_ff  <= 8'h00;
      dmap_ff   <= '0;
    end else begin
      status_ff <= nxt_status;
      ptr_ff    <= nxt_ptr;
      pclath_ff <= nxt_pclath;
      intcon_ff <= nxt_intcon;
      rdata_ff  <= nxt_rdata;
      dmap_ff   <= nxt_dmap;
    end
  end

  always_comb begin
    pc_out               = pc_ff;
    insn_out             = insn_ff;
    dmap_out             = dmap_ff;
    rdata_out            = rdata_ff;
    status_out           = status_ff;
    indirect_pointer_out = ptr_ff;
    ee_addr_out          = ee_ff;
  end
endmodule

// ==== src/mmb_pkg.sv ====
package mmb_pkg;
  localparam int unsigned PC_W         = 13;
  localparam int unsigned INSN_W       = 14;
  localparam int unsigned DADDR_W      = 9;
  localparam int unsigned OFS_W        = 7;
  localparam int unsigned BANK_W       = 2;
  localparam int unsigned STAT_BSH_BIT = 6;
  localparam int unsigned STAT_BSL_BIT = 5;
  localparam int unsigned PROG_AW_SML  = 10;
  localparam int unsigned PROG_AW_LRG  = 11;
  localparam int unsigned EE_AW_SML    = 7;
  localparam int unsigned EE_AW_LRG    = 8;
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [12:0] IRQ_VECTOR   = 13'h0004;
  localparam logic [6:0]  OFS_MAX      = 7'h7f;
  localparam logic [6:0]  GPR_FIRST    = 7'h20;
  localparam logic [6:0]  INDIRECT_OFS = 7'h00;
  localparam logic [6:0]  PCL_OFS      = 7'h02;
  localparam logic [6:0]  STATUS_OFS   = 7'h03;
  localparam logic [6:0]  PTR_OFS      = 7'h04;
  localparam logic [6:0]  PCLATH_OFS   = 7'h0a;
  localparam logic [6:0]  INTCON_OFS   = 7'h0b;
  localparam logic [7:0]  STATUS_RST   = 8'h18;

  typedef enum logic [1:0] {
    MMB_SEL_NONE = 2'b00,
    MMB_SEL_SFR  = 2'b01,
    MMB_SEL_GPR  = 2'b11
  } mmb_sel_e;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       indirect;
    logic [6:0] offset;
    logic [7:0] wdata;
  } mmb_dreq_s;

  typedef struct packed {
    logic [8:0] addr;
    logic [1:0] bank;
    logic [6:0] offset;
    logic       sel_sfr;
    logic       sel_gpr;
    logic       mirrored;
  } mmb_dmap_s;
endpackage

// ==== testbench/mmb_checker.sv ====
module mmb_checker #(
  parameter bit LARGE = 1'b0  // Size variant
) (
  input wire logic               clk_in,               // Clock
  input wire logic               arst_n_in,            // Reset
  input wire logic               pc_load_in,           // Jump
  input wire logic               irq_take_in,          // Interrupt
  input wire mmb_pkg::mmb_dreq_s dreq_in,              // Data request
  input wire logic               ee_ptr_wr_in,         // Pointer load
  input wire logic [7:0]         ee_ptr_in,            // Pointer value
  input wire logic [12:0]        pc_out,               // Counter
  input wire mmb_pkg::mmb_dmap_s dmap_out,             // Decode
  input wire logic [7:0]         status_out,           // Status
  input wire logic [7:0]         indirect_pointer_out, // Pointer
  input wire logic [7:0]         ee_addr_out           // EEPROM pointer
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] up_ff;
  logic       run;
  // Core registers only move from the third edge after release
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      up_ff <= 2'h0;
    end else if (up_ff != 2'h3) begin
      up_ff <= up_ff + 2'h1;
    end
  end
  assign run = (up_ff == 2'h3);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_dwr(logic [6:0] ofs);
    run && dreq_in.valid && dreq_in.write && !dreq_in.indirect && dreq_in.offset == ofs;
  endsequence
  chk_reset_vec: assert property (!run |-> pc_out == mmb_pkg::RESET_VECTOR)
    else $error("counter left reset vector");
  chk_pc_step: assert property (run && !pc_load_in && !irq_take_in
    |=> pc_out == $past(pc_out) + 13'h0001) else $error("counter did not step");
  chk_irq_vec: assert property (run && irq_take_in |=> pc_out == mmb_pkg::IRQ_VECTOR)
    else $error("interrupt vector wrong");
  chk_bank_join: assert property (run && dreq_in.valid && !dreq_in.indirect
    |=> dmap_out.addr == {$past(status_out[6:5]), $past(dreq_in.offset)})
    else $error("direct address wrong");
  chk_area_split: assert property ((dmap_out.sel_sfr || dmap_out.sel_gpr)
    |-> dmap_out.sel_gpr == (dmap_out.offset >= mmb_pkg::GPR_FIRST)) else $error("area wrong");
  chk_status_wr: assert property (s_dwr(mmb_pkg::STATUS_OFS)
    |=> status_out == $past(dreq_in.wdata)) else $error("status not written");
  chk_ptr_wr: assert property (s_dwr(mmb_pkg::PTR_OFS)
    |=> indirect_pointer_out == $past(dreq_in.wdata)) else $error("pointer not written");
  chk_ee_ptr: assert property (run && ee_ptr_wr_in
    |=> ee_addr_out == ($past(ee_ptr_in) & (LARGE ? 8'hff : 8'h7f))) else $error("ee pointer");
endmodule
bind mmb_memory_map mmb_checker #(.LARGE(LARGE)) chk_u (.clk_in(clk_in), .arst_n_in(arst_n_in),
  .pc_load_in(pc_load_in), .irq_take_in(irq_take_in), .dreq_in(dreq_in),
  .ee_ptr_wr_in(ee_ptr_wr_in), .ee_ptr_in(ee_ptr_in), .pc_out(pc_out), .dmap_out(dmap_out),
  .status_out(status_out), .indirect_pointer_out(indirect_pointer_out),
  .ee_addr_out(ee_addr_out));

// ==== testbench/mmb_core_model.sv ====
module mmb_core_model (
  input  wire logic         clk_in,         // Clock
  output logic              pc_load_out,    // Jump
  output logic [12:0]       pc_target_out,  // Target
  output logic              irq_take_out,   // Interrupt
  output logic              prog_wr_out,    // Program write
  output logic [12:0]       prog_waddr_out, // Program address
  output logic [13:0]       prog_wdata_out, // Program word
  output mmb_pkg::mmb_dreq_s dreq_out,      // Data request
  output logic              ee_ptr_wr_out,  // EEPROM pointer load
  output logic [7:0]        ee_ptr_out      // EEPROM pointer value
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic clr();
    {pc_load_out, pc_target_out, irq_take_out, prog_wr_out} = '0;
    {prog_waddr_out, prog_wdata_out, dreq_out, ee_ptr_wr_out, ee_ptr_out} = '0;
  endtask
  initial clr();
  task automatic idle();
    @(negedge clk_in);
    clr();
  endtask
  task automatic pwr(input logic [12:0] a, input logic [13:0] d);
    @(negedge clk_in);
    {prog_wr_out, prog_waddr_out, prog_wdata_out} = {1'b1, a, d};
  endtask
  task automatic jmp(input logic [12:0] t, input logic irq);
    @(negedge clk_in);
    {pc_load_out, pc_target_out, irq_take_out} = {1'b1, t, irq};
    @(negedge clk_in);
    {pc_load_out, irq_take_out} = 2'b00;
  endtask
  task automatic dacc(input logic w, input logic ind, input logic [6:0] o, input logic [7:0] d);
    @(negedge clk_in);
    dreq_out = '{1'b1, w, ind, o, d};
  endtask
  task automatic eeld(input logic [7:0] v);
    @(negedge clk_in);
    {ee_ptr_wr_out, ee_ptr_out} = {1'b1, v};
  endtask
endmodule

// ==== testbench/testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk_in, arst_n_in, pc_load, irq_take, prog_wr, ee_ptr_wr;
  logic [12:0]        pc_target, prog_waddr, pc;
  logic [13:0]        prog_wdata, insn;
  logic [7:0]         ee_ptr, rdata, status, iptr, ee_addr;
  mmb_pkg::mmb_dreq_s dreq;
  mmb_pkg::mmb_dmap_s dmap;
  int                 n_fail, samples_checked;
  mmb_core_model core_u (.clk_in(clk_in), .pc_load_out(pc_load), .pc_target_out(pc_target),
    .irq_take_out(irq_take), .prog_wr_out(prog_wr), .prog_waddr_out(prog_waddr),
    .prog_wdata_out(prog_wdata), .dreq_out(dreq), .ee_ptr_wr_out(ee_ptr_wr), .ee_ptr_out(ee_ptr));
  mmb_memory_map #(.LARGE(1'b0)) dut_u (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .pc_load_in(pc_load), .pc_target_in(pc_target), .irq_take_in(irq_take),
    .prog_wr_in(prog_wr), .prog_waddr_in(prog_waddr), .prog_wdata_in(prog_wdata),
    .dreq_in(dreq), .ee_ptr_wr_in(ee_ptr_wr), .ee_ptr_in(ee_ptr), .pc_out(pc), .insn_out(insn),
    .dmap_out(dmap), .rdata_out(rdata), .status_out(status), .indirect_pointer_out(iptr),
    .ee_addr_out(ee_addr));
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic rd(input logic [6:0] o, input logic ind, input logic [7:0] e, input logic [8:0] a);
    core_u.dacc(1'b0, ind, o, 8'h00);
    @(posedge clk_in);
    #1;
    chk(rdata, e);
    chk(dmap.addr, a);
  endtask
  task automatic t_prog();
    core_u.pwr(13'h0020, 14'h2a5c);
    core_u.pwr(13'h1c21, 14'h1337);
    core_u.pwr(13'h03ff, 14'h3c0f);
    core_u.idle();
    core_u.jmp(13'h1820, 1'b0);
    chk(pc, 13'h1820);
    @(negedge clk_in);
    chk(insn, 14'h2a5c);
    @(negedge clk_in);
    chk(insn, 14'h1337);
    core_u.jmp(13'h1fff, 1'b0);
    @(negedge clk_in);
    chk(pc, 13'h0000);
    chk(insn, 14'h3c0f);
    core_u.jmp(13'h0100, 1'b1);
    chk(pc, mmb_pkg::IRQ_VECTOR);
  endtask
  task automatic t_banks();
    for (int b = 0; b < 4; b++) begin
      core_u.dacc(1'b1, 1'b0, mmb_pkg::STATUS_OFS, {1'b0, b[1:0], 5'h00});
      core_u.dacc(1'b1, 1'b0, 7'h7f, 8'h10 + b[7:0]);
    end
    for (int b = 0; b < 4; b++) begin
      core_u.dacc(1'b1, 1'b0, mmb_pkg::STATUS_OFS, {1'b0, b[1:0], 5'h00});
      rd(7'h7f, 1'b0, 8'h10 + b[7:0], {b[1:0], 7'h7f});
    end
    rd(mmb_pkg::STATUS_OFS, 1'b0, 8'h60, 9'h183);
    chk(dmap.mirrored, 1'b1);
    chk(dmap.bank, 2'h3);
    core_u.dacc(1'b1, 1'b0, mmb_pkg::PTR_OFS, 8'hff);
    core_u.dacc(1'b1, 1'b0, mmb_pkg::STATUS_OFS, 8'h00);
    rd(mmb_pkg::PTR_OFS, 1'b0, 8'hff, 9'h004);
    rd(7'h00, 1'b1, 8'h11, 9'h0ff);
    core_u.dacc(1'b1, 1'b0, 7'h10, 8'h5a);
    rd(7'h10, 1'b0, 8'h00, 9'h010);
    chk(dmap.sel_sfr, 1'b1);
    chk(dmap.mirrored, 1'b0);
    core_u.jmp(13'h0c20, 1'b0);
    rd(7'h7f, 1'b0, 8'h10, 9'h07f);
    chk(insn, 14'h1337);
    chk(dmap.sel_gpr, 1'b1);
    core_u.eeld(8'ha5);
    core_u.idle();
    chk(ee_addr, 8'h25);
  endtask
  initial begin
    n_fail = 0;
    samples_checked = 0;
    arst_n_in = 1'b0;
    repeat (16) @(negedge clk_in);
    chk(pc, mmb_pkg::RESET_VECTOR);
    arst_n_in = 1'b1;
    repeat (3) @(negedge clk_in);
    t_prog();
    t_banks();
    close_out();
  end
  initial begin
    repeat (2000) @(posedge clk_in);
    n_fail++;
    close_out();
  end
endmodule
